// file: logic/epc_counter.sv
// Two-channel encoder pulse counter with AXI4-Lite settings
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module epc_counter #(
  parameter int TICK_CYCLES = epc_pkg::MS_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [epc_pkg::CH_N-1:0] enc_a,
  input wire logic [epc_pkg::CH_N-1:0] enc_b,
  output var logic override_mode,
  input wire logic [epc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output var logic s_axi_awready,
  input wire logic [epc_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output var logic s_axi_wready,
  output var logic [1:0] s_axi_bresp,
  output var logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [epc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output var logic s_axi_arready,
  output var logic [epc_pkg::DATA_W-1:0] s_axi_rdata,
  output var logic [1:0] s_axi_rresp,
  output var logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import epc_pkg::*;
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    epc_mode_t mode;
    logic [1:0] unit;
    logic [1:0] spd;
    logic [31:0] ppr;
    logic [31:0] travel;
    logic [31:0] maxv;
    logic [31:0] minv;
    logic [TC_W-1:0] tc;
    logic [31:0] cnt;
    logic [31:0] avg;
  } epc_chan_t;
  typedef struct packed {
    epc_chan_t [CH_N-1:0] ch;
    logic ovr;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } epc_state_t;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  epc_state_t s_reg;
  epc_state_t s_next;
  logic [CH_N-1:0] step_inc;
  logic [CH_N-1:0] step_dec;

  // ----------------------------------------------------------------
  // Channel decoders
  // ----------------------------------------------------------------
  for (genvar g = 0; g < CH_N; g++) begin : g_ch
    epc_step_if stp();
    assign stp.mode = s_reg.ch[g].mode;
    assign step_inc[g] = stp.inc;
    assign step_dec[g] = stp.dec;
    epc_decoder u_dec (
      .aclk(aclk),
      .aresetn(aresetn),
      .a_pin(enc_a[g]),
      .b_pin(enc_b[g]),
      .stp(stp)
    );
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge
  // Smoothing shift grows with the time constant's bit length
  function automatic logic [3:0] filt_shift(input logic [TC_W-1:0] tc);
    logic [3:0] s;
    s = 4'h1;
    for (int i = 0; i < TC_W; i++) begin
      if (tc[i]) begin
        s = 4'(i + 1);
      end
    end
    return s;
  endfunction : filt_shift
  function automatic logic [31:0] cfg_word(input epc_chan_t c);
    logic [31:0] w;
    w = '0;
    w[CFG_MODE_LSB +: 3] = c.mode;
    w[CFG_UNIT_LSB +: 2] = c.unit;
    w[CFG_SPD_LSB +: 2] = c.spd;
    return w;
  endfunction : cfg_word
  // Channel index from address, or -1 if outside every channel window
  function automatic int chan_of(input logic [ADDR_W-1:0] a);
    int r;
    r = -1;
    for (int i = 0; i < CH_N; i++) begin
      if (a >= ADDR_W'(i * CH_STRIDE) && a < ADDR_W'((i + 1) * CH_STRIDE)) begin
        r = i;
      end
    end
    return r;
  endfunction : chan_of

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    int ci;
    logic [ADDR_W-1:0] ofs;
    logic [31:0] w;
    logic signed [32:0] diff;
    logic signed [32:0] stepv;
    ci = 0;
    ofs = '0;
    w = '0;
    diff = '0;
    stepv = '0;
    s_next = s_reg;
    // Millisecond enable for the filter
    s_next.tick = (s_reg.tick_cnt == TICK_LAST);
    s_next.tick_cnt = s_next.tick ? '0 : s_reg.tick_cnt + 1'b1;
    for (int i = 0; i < CH_N; i++) begin
      // One step per decoded edge, wrapping at the limits
      if (step_inc[i]) begin
        if ($signed(s_reg.ch[i].cnt) >= $signed(s_reg.ch[i].maxv)) begin
          s_next.ch[i].cnt = s_reg.ch[i].minv;
        end else begin
          s_next.ch[i].cnt = s_reg.ch[i].cnt + 32'h1;
        end
      end else if (step_dec[i]) begin
        if ($signed(s_reg.ch[i].cnt) <= $signed(s_reg.ch[i].minv)) begin
          s_next.ch[i].cnt = s_reg.ch[i].maxv;
        end else begin
          s_next.ch[i].cnt = s_reg.ch[i].cnt - 32'h1;
        end
      end
      // First-order average; zero time constant follows the count directly
      if (s_reg.ch[i].tc == '0) begin
        s_next.ch[i].avg = s_reg.ch[i].cnt;
      end else if (s_reg.tick) begin
        diff = $signed({s_reg.ch[i].cnt[31], s_reg.ch[i].cnt})
             - $signed({s_reg.ch[i].avg[31], s_reg.ch[i].avg});
        stepv = diff >>> filt_shift(s_reg.ch[i].tc);
        s_next.ch[i].avg = s_reg.ch[i].avg + stepv[31:0];
      end
    end
    // Write channel: address and data in either order
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.awaddr = s_axi_awaddr;
      s_next.aw_got = 1'b1;
      s_next.awready = 1'b0;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
      s_next.w_got = 1'b1;
      s_next.wready = 1'b0;
    end
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      ci = chan_of(s_reg.awaddr);
      if (ci >= 0) begin
        ofs = s_reg.awaddr - ADDR_W'(ci * CH_STRIDE);
        case (ofs)
          OFS_CFG: begin
            w = merge(cfg_word(s_reg.ch[ci]), s_reg.wdata, s_reg.wstrb);
            // Out-of-range codes leave the field unchanged
            if (w[CFG_MODE_LSB +: 3] <= MODE_LAST) begin
              s_next.ch[ci].mode = w[CFG_MODE_LSB +: 3];
            end
            if (w[CFG_UNIT_LSB +: 2] <= UNIT_LAST) begin
              s_next.ch[ci].unit = w[CFG_UNIT_LSB +: 2];
            end
            if (w[CFG_SPD_LSB +: 2] <= SPD_LAST) begin
              s_next.ch[ci].spd = w[CFG_SPD_LSB +: 2];
            end
          end
          OFS_PPR: begin
            w = merge(s_reg.ch[ci].ppr, s_reg.wdata, s_reg.wstrb);
            if (w != '0) begin
              s_next.ch[ci].ppr = w;
            end
          end
          OFS_TRAVEL: begin
            s_next.ch[ci].travel = merge(s_reg.ch[ci].travel, s_reg.wdata,
                                         s_reg.wstrb);
          end
          OFS_MAXV: begin
            s_next.ch[ci].maxv = merge(s_reg.ch[ci].maxv, s_reg.wdata, s_reg.wstrb);
          end
          OFS_MINV: begin
            s_next.ch[ci].minv = merge(s_reg.ch[ci].minv, s_reg.wdata, s_reg.wstrb);
          end
          OFS_FILT: begin
            w = merge({22'h0, s_reg.ch[ci].tc}, s_reg.wdata, s_reg.wstrb);
            s_next.ch[ci].tc = (w > {22'h0, TC_MAX_MS}) ? TC_MAX_MS : w[TC_W-1:0];
          end
          OFS_COUNT: begin
            // Preset wins over a step in the same cycle
            s_next.ch[ci].cnt = merge(s_reg.ch[ci].cnt, s_reg.wdata, s_reg.wstrb);
          end
          // Average is read-only; writes to it fall here
          default: begin
            s_next.bresp = RESP_SLVERR;
          end
        endcase
      end else if (s_reg.awaddr == OFS_GLOBAL) begin
        if (s_reg.wstrb[0]) begin
          s_next.ovr = s_reg.wdata[0];
        end
      end else begin
        s_next.bresp = RESP_SLVERR;
      end
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
    end
    // Read channel
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      s_next.rdata = '0;
      ci = chan_of(s_axi_araddr);
      if (ci >= 0) begin
        ofs = s_axi_araddr - ADDR_W'(ci * CH_STRIDE);
        case (ofs)
          OFS_CFG: s_next.rdata = cfg_word(s_reg.ch[ci]);
          OFS_PPR: s_next.rdata = s_reg.ch[ci].ppr;
          OFS_TRAVEL: s_next.rdata = s_reg.ch[ci].travel;
          OFS_MAXV: s_next.rdata = s_reg.ch[ci].maxv;
          OFS_MINV: s_next.rdata = s_reg.ch[ci].minv;
          OFS_FILT: s_next.rdata = {22'h0, s_reg.ch[ci].tc};
          OFS_COUNT: s_next.rdata = s_reg.ch[ci].cnt;
          OFS_AVG: s_next.rdata = s_reg.ch[ci].avg;
          default: s_next.rresp = RESP_SLVERR;
        endcase
      end else if (s_axi_araddr == OFS_GLOBAL) begin
        s_next.rdata = {31'h0, s_reg.ovr};
      end else begin
        s_next.rresp = RESP_SLVERR;
      end
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      for (int i = 0; i < CH_N; i++) begin
        s_reg.ch[i].mode <= RST_MODE;
        s_reg.ch[i].unit <= UNIT_PULSE;
        s_reg.ch[i].spd <= SPD_UNIT_SEC;
        s_reg.ch[i].ppr <= RST_PPR;
        s_reg.ch[i].travel <= RST_TRAVEL;
        s_reg.ch[i].maxv <= RST_MAXV;
        s_reg.ch[i].minv <= RST_MINV;
        s_reg.ch[i].tc <= RST_TC;
      end
      s_reg.ovr <= RST_OVR;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end
  assign override_mode = s_reg.ovr;
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
endmodule : epc_counter
`default_nettype wire

// file: logic/epc_pkg.sv
// Shared constants and types of the encoder pulse input counter
`default_nettype none
package epc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CH_N = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int TC_W = 10;
  localparam int TICK_W = 15;

  // ----------------------------------------------------------------
  // Input modes
  // ----------------------------------------------------------------
  typedef logic [2:0] epc_mode_t;
  localparam epc_mode_t MODE_UPDN_X1 = 3'h0;
  localparam epc_mode_t MODE_STEPDIR_X1 = 3'h1;
  localparam epc_mode_t MODE_STEPDIR_X2 = 3'h2;
  localparam epc_mode_t MODE_QUAD_X1 = 3'h3;
  localparam epc_mode_t MODE_QUAD_X2 = 3'h4;
  localparam epc_mode_t MODE_QUAD_X4 = 3'h5;
  localparam epc_mode_t MODE_LAST = MODE_QUAD_X4;

  // ----------------------------------------------------------------
  // Reset values and limits of the channel settings, and the override reset value
  // ----------------------------------------------------------------
  localparam epc_mode_t RST_MODE = MODE_QUAD_X1;
  localparam logic [1:0] UNIT_PULSE = 2'h0;
  localparam logic [1:0] UNIT_LAST = 2'h3;
  localparam logic [1:0] SPD_UNIT_SEC = 2'h0;
  localparam logic [1:0] SPD_LAST = 2'h2;
  localparam logic [31:0] RST_PPR = 32'h0000_2000;
  localparam logic [31:0] RST_TRAVEL = 32'h0000_000a;
  localparam logic [31:0] RST_MAXV = 32'h7fff_ffff;
  localparam logic [31:0] RST_MINV = 32'h8000_0000;
  localparam logic [TC_W-1:0] RST_TC = 10'h000;
  localparam logic [TC_W-1:0] TC_MAX_MS = 10'h3e8;
  localparam logic RST_OVR = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int FILT_STEP_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * FILT_STEP_MS;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CH_STRIDE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PPR = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TRAVEL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MAXV = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_MINV = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FILT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_AVG = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL = 8'h40;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_UNIT_LSB = 4;
  localparam int CFG_SPD_LSB = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : epc_pkg
`default_nettype wire

// file: logic/epc_step_if.sv
// Step carrier between a channel decoder and the counter
`timescale 1ns/1ns
`default_nettype none
interface epc_step_if;
  import epc_pkg::*;
  epc_mode_t mode;
  logic inc;
  logic dec;
  modport dec_side(input mode, output inc, output dec);
  modport cnt_side(output mode, input inc, input dec);
endinterface : epc_step_if
`default_nettype wire

// file: logic/epc_decoder.sv
// Pin synchroniser and step decoder for one encoder channel
`timescale 1ns/1ns
`default_nettype none
module epc_decoder (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic a_pin,
  input wire logic b_pin,
  epc_step_if.dec_side stp
);
  import epc_pkg::*;

  typedef struct packed {
    logic [2:0] sa;
    logic [2:0] sb;
    logic la;
    logic lb;
    logic inc;
    logic dec;
  } epc_dec_state_t;

  epc_dec_state_t s_reg;
  epc_dec_state_t s_next;

  logic a_new;
  logic b_new;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;

  always_comb begin
    s_next = s_reg;
    s_next.sa = {s_reg.sa[1:0], a_pin};
    s_next.sb = {s_reg.sb[1:0], b_pin};
    // Level moves only once stages two and three agree
    a_new = (s_reg.sa[1] == s_reg.sa[2]) ? s_reg.sa[2] : s_reg.la;
    b_new = (s_reg.sb[1] == s_reg.sb[2]) ? s_reg.sb[2] : s_reg.lb;
    s_next.la = a_new;
    s_next.lb = b_new;
    a_rise = a_new & ~s_reg.la;
    a_fall = ~a_new & s_reg.la;
    b_rise = b_new & ~s_reg.lb;
    b_fall = ~b_new & s_reg.lb;
    s_next.inc = 1'b0;
    s_next.dec = 1'b0;
    case (stp.mode)
      MODE_UPDN_X1: begin
        s_next.inc = a_rise & ~b_new & ~b_rise;
        s_next.dec = b_rise & ~a_new & ~a_rise;
      end
      MODE_STEPDIR_X1: begin
        s_next.inc = a_rise & ~b_new;
        s_next.dec = a_rise & b_new;
      end
      MODE_STEPDIR_X2: begin
        s_next.inc = (a_rise | a_fall) & ~b_new;
        s_next.dec = (a_rise | a_fall) & b_new;
      end
      MODE_QUAD_X1: begin
        // Both pins moving at once is an illegal quadrature step
        s_next.inc = a_rise & ~b_new & ~b_rise & ~b_fall;
        s_next.dec = a_fall & ~b_new & ~b_rise & ~b_fall;
      end
      MODE_QUAD_X2: begin
        s_next.inc = ~(b_rise | b_fall) & ((a_rise & ~b_new) | (a_fall & b_new));
        s_next.dec = ~(b_rise | b_fall) & ((a_rise & b_new) | (a_fall & ~b_new));
      end
      MODE_QUAD_X4: begin
        if ((a_rise | a_fall) ^ (b_rise | b_fall)) begin
          s_next.inc = (a_rise & ~b_new) | (a_fall & b_new)
                     | (b_rise & a_new) | (b_fall & ~a_new);
          s_next.dec = (a_rise & b_new) | (a_fall & ~b_new)
                     | (b_rise & ~a_new) | (b_fall & a_new);
        end
      end
      default: begin
        s_next.inc = 1'b0;
        s_next.dec = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign stp.inc = s_reg.inc;
  assign stp.dec = s_reg.dec;

endmodule : epc_decoder
`default_nettype wire

// file: bench/epc_counter_properties.sv
// Port-level timing checks of the encoder pulse counter
`timescale 1ns/1ns
`default_nettype none
module epc_counter_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic override_mode,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [epc_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import epc_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  write_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response late");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response not retired");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read response not retired");
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
    else $error("error read carries data");
  // ----------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------
  ovr_write_a: assert property (!$stable(override_mode) |-> $rose(s_axi_bvalid))
    else $error("override mode changed without write");
  reset_idle_a: assert property ($rose(aresetn) |-> s_axi_awready && s_axi_arready
    && !s_axi_bvalid && !s_axi_rvalid && !override_mode) else $error("bad state after reset");
endmodule : epc_counter_checker
bind epc_counter epc_counter_checker u_props (.aclk(aclk), .aresetn(aresetn),
  .override_mode(override_mode), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// file: bench/epc_enc_model.sv
// Encoder and pulse generator model for both channels
`timescale 1ns/1ns
`default_nettype none
module epc_enc_model (
  input wire logic aclk,
  output var logic [1:0] enc_a,
  output var logic [1:0] enc_b
);
  import epc_pkg::*;
  initial begin
    enc_a = 2'h0;
    enc_b = 2'h0;
  end
  // Four clocks per level keeps edges well clear of the sync window
  task automatic set(input int ch, input logic a, input logic b);
    repeat (4) @(posedge aclk);
    enc_a[ch] <= a;
    enc_b[ch] <= b;
  endtask : set
  // One unit of motion in the output form of the chosen mode
  task automatic move(input int ch, input epc_mode_t m, input logic dn);
    case (m)
      MODE_UPDN_X1: begin
        set(ch, !dn, dn);
        set(ch, 1'b0, 1'b0);
      end
      MODE_STEPDIR_X1, MODE_STEPDIR_X2: begin
        set(ch, 1'b0, dn);
        set(ch, 1'b1, dn);
        set(ch, 1'b0, dn);
        set(ch, 1'b0, 1'b0);
      end
      default: begin
        set(ch, !dn, dn);
        set(ch, 1'b1, 1'b1);
        set(ch, dn, !dn);
        set(ch, 1'b0, 1'b0);
      end
    endcase
  endtask : move
endmodule : epc_enc_model
`default_nettype wire

// file: bench/encoder_pulse_input_counter_tb.sv
// Register and counting tests of the encoder pulse counter
`timescale 1ns/1ns
`default_nettype none
module encoder_pulse_input_counter_tb;
  import epc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, override_mode;
  logic [1:0] enc_a, enc_b, bresp, rresp;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  int n_fail = 0, comparisons = 0;
  epc_enc_model enc (.aclk(aclk), .enc_a(enc_a), .enc_b(enc_b));
  epc_counter #(.TICK_CYCLES(8)) dut (.aclk(aclk), .aresetn(aresetn), .enc_a(enc_a),
    .enc_b(enc_b), .override_mode(override_mode), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  initial begin
    forever #25 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask : w
  task automatic r(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    chk("rdata", rdata, e);
    rready <= 1'b0;
  endtask : r
  task automatic print_verdict();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] ofs[8];
    logic [31:0] dv[8];
    int fw[6];
    logic [7:0] ba;
    ofs = '{OFS_CFG, OFS_PPR, OFS_TRAVEL, OFS_MAXV, OFS_MINV, OFS_FILT, OFS_COUNT, OFS_AVG};
    dv = '{32'h3, RST_PPR, RST_TRAVEL, RST_MAXV, RST_MINV, 32'h0, 32'h0, 32'h0};
    fw = '{1, 1, 2, 1, 2, 4};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int c = 0; c < CH_N; c++) begin
      for (int i = 0; i < 8; i++) r(8'(c * 32) + ofs[i], dv[i], RESP_OKAY);
    end
    r(OFS_GLOBAL, 32'h0, RESP_OKAY);
    r(8'h60, 32'h0, RESP_SLVERR);
    w(OFS_AVG, 32'h5, RESP_SLVERR);
    $display("test reset values done");
    // Three units forward, one back, channels alternate
    for (int m = 0; m <= 5; m++) begin
      ba = (m % 2) ? CH_STRIDE : 8'h00;
      w(ba + OFS_CFG, 32'(m), RESP_OKAY);
      w(ba + OFS_COUNT, 32'h0, RESP_OKAY);
      repeat (3) enc.move(m % 2, epc_mode_t'(m), 1'b0);
      enc.move(m % 2, epc_mode_t'(m), 1'b1);
      repeat (10) @(posedge aclk);
      r(ba + OFS_COUNT, 32'(2 * fw[m]), RESP_OKAY);
      r(ba + OFS_AVG, 32'(2 * fw[m]), RESP_OKAY);
    end
    $display("test input modes done");
    w(CH_STRIDE + OFS_MAXV, 32'h5, RESP_OKAY);
    w(CH_STRIDE + OFS_MINV, 32'hffff_fffd, RESP_OKAY);
    w(CH_STRIDE + OFS_COUNT, 32'h4, RESP_OKAY);
    enc.move(1, MODE_QUAD_X4, 1'b0);
    repeat (10) @(posedge aclk);
    r(CH_STRIDE + OFS_COUNT, 32'hffff_ffff, RESP_OKAY);
    enc.move(1, MODE_QUAD_X4, 1'b1);
    repeat (10) @(posedge aclk);
    r(CH_STRIDE + OFS_COUNT, 32'h4, RESP_OKAY);
    $display("test wrap done");
    w(OFS_CFG, 32'h7, RESP_OKAY);
    r(OFS_CFG, 32'h4, RESP_OKAY);
    w(OFS_CFG, 32'h334, RESP_OKAY);
    r(OFS_CFG, 32'h34, RESP_OKAY);
    w(OFS_CFG, 32'h224, RESP_OKAY);
    r(OFS_CFG, 32'h224, RESP_OKAY);
    w(OFS_PPR, 32'h0, RESP_OKAY);
    r(OFS_PPR, RST_PPR, RESP_OKAY);
    w(CH_STRIDE + OFS_TRAVEL, 32'h32, RESP_OKAY);
    r(CH_STRIDE + OFS_TRAVEL, 32'h32, RESP_OKAY);
    w(OFS_FILT, 32'h7d0, RESP_OKAY);
    r(OFS_FILT, {22'h0, TC_MAX_MS}, RESP_OKAY);
    w(OFS_GLOBAL, 32'h1, RESP_OKAY);
    @(posedge aclk);
    chk("override_mode", {31'h0, override_mode}, 32'h1);
    r(OFS_GLOBAL, 32'h1, RESP_OKAY);
    $display("test settings done");
    print_verdict();
  end
  // Whole run needs well under a thousand clocks
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    $display("ERROR watchdog expected finish seen timeout");
    print_verdict();
  end
endmodule : encoder_pulse_input_counter_tb
`default_nettype wire
